// ### bench/dcf_pin_model.sv
// Purpose: Writer and reader logic facing the FIFO pins
// Assumes: Free-running 64 ns pin clocks, phase unrelated to sys_clk
// Notes:   Pins change on falling pin edges; hits count rising edges with an enable low
`timescale 1ns/1ps
module dcf_pin_model (
  input  wire logic       wr_go,
  input  wire logic       rd_go,
  input  wire logic       dual,
  input  wire logic [1:0] rd_mask,
  input  wire logic [8:0] wdat,
  output logic            wr_clk,
  output logic            rd_clk,
  output logic            write_enable_primary_n,
  output logic            write_enable_second_or_load,
  output logic            read_enable_a_n,
  output logic            read_enable_b_n,
  output logic      [8:0] write_data,
  output int              wr_hits,
  output int              rd_hits
);
  initial begin
    {wr_clk, rd_clk, wr_hits, rd_hits, write_data} = '0;
    write_enable_primary_n = 1'b1;
    write_enable_second_or_load = 1'b1;
    {read_enable_a_n, read_enable_b_n} = 2'b11;
    #3;
    fork
      forever #32 wr_clk = ~wr_clk;
      #16 forever #32 rd_clk = ~rd_clk;
    join
  end
  // Released data toggles so a stale word never looks valid
  always @(negedge wr_clk) begin
    write_enable_primary_n <= !wr_go;
    write_enable_second_or_load <= dual;
    write_data <= wr_go ? wdat : ~write_data;
  end
  always @(negedge rd_clk)
    {read_enable_a_n, read_enable_b_n} <= rd_go ? ~rd_mask : 2'b11;
  always @(posedge wr_clk)
    if (!write_enable_primary_n) wr_hits <= wr_hits + 1;
  always @(posedge rd_clk)
    if (!(read_enable_a_n && read_enable_b_n)) rd_hits <= rd_hits + 1;
endmodule

// ### bench/testbench.sv
// Purpose: Self-checking bench for the dual-clock nine-bit FIFO
// Assumes: Depth cut to 16 words; pin clocks come from the partner
// Notes:   Queue model of array, offsets and flags checked at each result
`timescale 1ns/1ps
`include "dcf_regs.svh"
module testbench;
  localparam int DEPTH = 16;
  logic        sys_clk, rst, ce, reset_n, output_enable_n, read_data_oe;
  logic        wr_go, rd_go, dual, two_we, wr_clk, rd_clk;
  logic [1:0]  rd_mask, s_axi_bresp, s_axi_rresp;
  logic [8:0]  wdat, last, read_data, write_data, ofs[4], q[$];
  logic [31:0] rnd, s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, empty_flag_n, full_flag_n;
  logic        write_enable_primary_n, write_enable_second_or_load;
  logic        read_enable_a_n, read_enable_b_n;
  logic        almost_empty_flag_n, almost_full_flag_n;
  int          wr_hits, rd_hits, sel, fails, samples_checked, i;
  int          seed = 32'h4b19_b99d;
  dcf_fifo #(.ADDR_W(4), .AXI_AW(4)) i_dcf_fifo (.sys_clk, .rst, .ce,
    .wr_clk, .rd_clk, .write_enable_primary_n, .write_enable_second_or_load,
    .read_enable_a_n, .read_enable_b_n, .reset_n, .output_enable_n,
    .write_data, .read_data, .read_data_oe, .empty_flag_n, .full_flag_n,
    .almost_empty_flag_n, .almost_full_flag_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  dcf_pin_model i_dcf_pin_model (.wr_go, .rd_go, .dual, .rd_mask, .wdat,
    .wr_clk, .rd_clk, .write_enable_primary_n, .write_enable_second_or_load,
    .read_enable_a_n, .read_enable_b_n, .write_data, .wr_hits, .rd_hits);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timed_out(input int k);
    if (k >= 50) begin
      fails++;
      $display("MISMATCH at %0t: no answer", $time);
      summarize;
    end
  endtask
  // Flags {full, almost full, almost empty, empty} from the queue model
  function automatic logic [3:0] exp_flags();
    int c, n, m;
    c = q.size();
    n = {ofs[1], ofs[0]} % DEPTH;
    m = {ofs[3], ofs[2]} % DEPTH;
    return {c != DEPTH, c < DEPTH - m, c > n, c != 0};
  endfunction
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    timed_out(k);
    chk(s_axi_bresp, er);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int k;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    timed_out(k);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask
  // Pin flags need a write edge plus three read edges to cross sides
  task automatic settle;
    repeat (48) @(posedge sys_clk);
    chk({full_flag_n, almost_full_flag_n, almost_empty_flag_n,
         empty_flag_n}, exp_flags());
  endtask
  task automatic pin_wr(input logic [8:0] d);
    int h, k;
    h = wr_hits;
    wdat <= d;
    wr_go <= 1'b1;
    for (k = 0; k < 50 && wr_hits == h; k++) @(posedge sys_clk);
    wr_go <= 1'b0;
    timed_out(k);
    if (dual && q.size() < DEPTH) q.push_back(d);
    else if (!dual && !two_we) begin
      ofs[sel] = d;
      sel = (sel + 1) % 4;
    end
    settle;
  endtask
  task automatic pin_rd(input logic [1:0] msk);
    int h, k;
    h = rd_hits;
    rd_mask <= msk;
    rd_go <= 1'b1;
    for (k = 0; k < 50 && rd_hits == h; k++) @(posedge sys_clk);
    rd_go <= 1'b0;
    timed_out(k);
    if (msk == 2'b11 && !dual && !two_we) begin
      last = ofs[sel];
      sel = (sel + 1) % 4;
    end else if (msk == 2'b11 && q.size() > 0) last = q.pop_front();
    settle;
    chk(read_data, last);
  endtask
  task automatic pin_reset(input logic d);
    dual <= d;
    reset_n <= 1'b0;
    q.delete();
    ofs = '{9'h007, 9'h000, 9'h007, 9'h000};
    {sel, two_we, last} = {32'h0, d, 9'h000};
    repeat (40) @(posedge sys_clk);
    reset_n <= 1'b1;
    settle;
    chk(read_data, 9'h000);
    axi_rd(`DCF_STAT_OFS, {two_we, exp_flags()}, `DCF_RESP_OKAY);
  endtask
  initial begin
    {rst, ce, reset_n, output_enable_n, dual} = 5'b11010;
    {wr_go, rd_go, rd_mask, wdat, fails, samples_checked} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 44'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    axi_rd(`DCF_CTRL_OFS, 32'h0000_0001, `DCF_RESP_OKAY);
    pin_reset(1'b0);
    for (i = 0; i < 4; i++) pin_rd(2'b11);
    for (i = 0; i < 4; i++) pin_wr(i[0] ? 9'h000 : 9'(i / 2 + 2));
    for (i = 0; i < 8; i++) pin_rd(2'b11);
    $display("Test offsets done");
    dual <= 1'b1;
    for (i = 0; i < DEPTH + 2; i++) begin
      rnd = $random(seed);
      pin_wr(rnd[8:0]);
    end
    axi_rd(`DCF_LEVEL_OFS, 32'(q.size()), `DCF_RESP_OKAY);
    pin_rd(2'b01);
    pin_rd(2'b10);
    for (i = 0; i < DEPTH + 1; i++) pin_rd(2'b11);
    $display("Test fill and drain done");
    output_enable_n <= 1'b0;
    settle;
    chk(read_data_oe, 1'b1);
    axi_wr(`DCF_CTRL_OFS, 32'h0000_0000, `DCF_RESP_OKAY);
    settle;
    chk(read_data_oe, 1'b0);
    axi_wr(4'hc, 32'h0000_0001, `DCF_RESP_SLVERR);
    axi_rd(4'hc, 32'h0000_0000, `DCF_RESP_SLVERR);
    $display("Test output enable done");
    pin_reset(1'b1);
    dual <= 1'b0;
    pin_wr(9'h1a5);
    dual <= 1'b1;
    pin_wr(9'h05a);
    pin_rd(2'b11);
    $display("Test two write enables done");
    summarize;
  end
endmodule

// ### hw/dcf_fifo.sv
// Purpose: Dual-clock nine-bit FIFO with empty, full and programmable flags
// Assumes: Pin clocks are far slower than sys_clk and sampled by it
// Notes:   Registers on AXI4-Lite; ce low freezes every flip-flop
//
// What this block does
// RULE1: Store nine-bit words in a dual-port array with write and read pointers.
// RULE2: Take words on a 9-bit input bus, give words on a 9-bit output bus.
// RULE3: Sample the dual-mode pin at reset: high second enable, low load.
// RULE4: Programmable-flag mode writes on write edge with primary enable low, not full.
// RULE5: Two-enable mode writes with primary low, second enable high, not full.
// RULE6: Writes while full store nothing and leave the write pointer still.
// RULE7: Load low with primary enable low writes data into offset registers.
// RULE8: Read only when both read enables are low.
// RULE9: Read edge with both enables low and not empty advances and outputs.
// RULE10: Load low with both read enables low reads offsets to outputs.
// RULE11: Empty flag low when nothing unread; updated by read edges only.
// RULE12: Full flag low when every location unread; updated by write edges.
// RULE13: Almost-empty flag follows the empty offset, timed by read edges.
// RULE14: Almost-full flag follows the full offset, timed by write edges.
// RULE15: Outputs driven while output enable low, released while it is high; here driving also needs the control register drive bit set.
// RULE16: The outside logic resets the buffer before the first access.
// RULE17: Reset empties the buffer, empty flag low, data outputs low.
// RULE18: The outside logic neither reads nor writes while reset is low.
// RULE19: All four flags take valid values on reset without a clock.
// RULE20: Four offset registers loaded in turn, then back to the first.
// RULE21: Almost-empty low at n or fewer words, high at n+1 or more.
// RULE22: Almost-full low at depth minus m words, high when free exceeds m.
// RULE23: Both offsets default to seven after reset.
// RULE24: Pointers cross sides as Gray codes through two-stage synchronisers.
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "dcf_regs.svh"

module dcf_fifo #(
  parameter int ADDR_W = 14,
  parameter int AXI_AW = 4
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              wr_clk,
  input  wire logic              rd_clk,
  input  wire logic              write_enable_primary_n,
  input  wire logic              write_enable_second_or_load,
  input  wire logic              read_enable_a_n,
  input  wire logic              read_enable_b_n,
  input  wire logic              reset_n,
  input  wire logic              output_enable_n,
  input  wire logic [8:0]        write_data,
  output logic      [8:0]        read_data,
  output logic                   read_data_oe,
  output logic                   empty_flag_n,
  output logic                   full_flag_n,
  output logic                   almost_empty_flag_n,
  output logic                   almost_full_flag_n,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  import dcf_pkg::*;

  localparam int CNT_W = ADDR_W + 1;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int PIN_W = $bits(dcf_pins_t);
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

  function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b[CNT_W-1] = g[CNT_W-1];
    for (int k = CNT_W - 2; k >= 0; k--) begin
      b[k] = b[k+1] ^ g[k];
    end
    return b;
  endfunction

  function automatic logic addr_known(input logic [AXI_AW-1:0] a);
    return (a == AXI_AW'(`DCF_CTRL_OFS)) || (a == AXI_AW'(`DCF_STAT_OFS)) ||
           (a == AXI_AW'(`DCF_LEVEL_OFS));
  endfunction

  // Pin sampling: three stages, a change counts when stages two and three agree
  dcf_pins_t        pin_in;
  dcf_pins_t        filt;
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] filt_v;
  logic [PIN_W-1:0] filt_next;

  assign pin_in = '{wr_clk: wr_clk, rd_clk: rd_clk,
                    write_enable_primary_n: write_enable_primary_n,
                    write_enable_second_or_load: write_enable_second_or_load,
                    read_enable_a_n: read_enable_a_n,
                    read_enable_b_n: read_enable_b_n,
                    reset_n: reset_n, output_enable_n: output_enable_n,
                    write_data: write_data};
  assign filt = filt_v;

  for (genvar i = 0; i < PIN_W; i++) begin : g_filt
    assign filt_next[i] = (sync2[i] == sync3[i]) ? sync2[i] : filt_v[i];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1  <= DCF_PINS_RST;
      sync2  <= DCF_PINS_RST;
      sync3  <= DCF_PINS_RST;
      filt_v <= DCF_PINS_RST;
    end else if (ce) begin
      sync1  <= pin_in;
      sync2  <= sync1;
      sync3  <= sync2;
      filt_v <= filt_next;
    end
  end

  // Edge finding on the sampled pin clocks
  logic wclk_prev_reg;
  logic rclk_prev_reg;
  logic pin_rst;
  logic w_ev;
  logic r_ev;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wclk_prev_reg <= 1'b0;
      rclk_prev_reg <= 1'b0;
    end else if (ce) begin
      wclk_prev_reg <= filt.wr_clk;
      rclk_prev_reg <= filt.rd_clk;
    end
  end

  assign pin_rst = !filt.reset_n;
  assign w_ev    = ce && !pin_rst && filt.wr_clk && !wclk_prev_reg;
  assign r_ev    = ce && !pin_rst && filt.rd_clk && !rclk_prev_reg;

  // Mode follows the dual-mode pin during reset and holds after release
  dcf_mode_t mode_reg;
  logic      prog_mode;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= DCF_MODE_PROG;
    end else if (ce && pin_rst) begin
      mode_reg <= filt.write_enable_second_or_load ? DCF_MODE_TWO_WE
                                                   : DCF_MODE_PROG; // RULE3
    end
  end

  assign prog_mode = (mode_reg == DCF_MODE_PROG);

  // Decoded write and read actions
  logic wr_fire;
  logic ofs_wr;
  logic rd_req;
  logic ofs_rd;
  logic arr_rd;

  // Both modes need the second pin high for an array write
  assign wr_fire = w_ev && !filt.write_enable_primary_n &&
                   filt.write_enable_second_or_load &&
                   full_flag_n; // RULE4 RULE5 RULE6
  assign ofs_wr  = w_ev && prog_mode && !filt.write_enable_primary_n &&
                   !filt.write_enable_second_or_load; // RULE7
  assign rd_req  = r_ev && !filt.read_enable_a_n &&
                   !filt.read_enable_b_n; // RULE8
  assign ofs_rd  = rd_req && prog_mode &&
                   !filt.write_enable_second_or_load; // RULE10
  assign arr_rd  = rd_req && !ofs_rd && empty_flag_n; // RULE9

  // Offset registers, one shared selector for loading and reading back
  logic [8:0]        ofs_reg [`DCF_OFS_NUM];
  logic [1:0]        ofs_sel_reg;
  logic [8:0]        ofs_cur;
  logic [ADDR_W-1:0] ofs_empty;
  logic [ADDR_W-1:0] ofs_full;
  logic [17:0]       ofs_e_cat;
  logic [17:0]       ofs_f_cat;

  assign ofs_cur   = ofs_reg[ofs_sel_reg];
  assign ofs_e_cat = {ofs_reg[1], ofs_reg[0]};
  assign ofs_f_cat = {ofs_reg[3], ofs_reg[2]};
  assign ofs_empty = ofs_e_cat[ADDR_W-1:0];
  assign ofs_full  = ofs_f_cat[ADDR_W-1:0];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ofs_sel_reg <= 2'h0;
      for (int k = 0; k < `DCF_OFS_NUM; k++) begin
        ofs_reg[k] <= (k[0] == 1'b0) ? `DCF_OFS_RST : 9'h000; // RULE23
      end
    end else if (ce) begin
      if (pin_rst) begin
        ofs_sel_reg <= 2'h0;
        for (int k = 0; k < `DCF_OFS_NUM; k++) begin
          ofs_reg[k] <= (k[0] == 1'b0) ? `DCF_OFS_RST : 9'h000; // RULE23
        end
      end else if (ofs_wr) begin
        ofs_reg[ofs_sel_reg] <= filt.write_data; // RULE7
        ofs_sel_reg          <= ofs_sel_reg + 2'h1; // RULE20
      end else if (ofs_rd) begin
        ofs_sel_reg <= ofs_sel_reg + 2'h1; // RULE20
      end
    end
  end

  // Storage array
  logic [8:0]       mem [DEPTH];
  logic [CNT_W-1:0] wptr_reg;
  logic [CNT_W-1:0] rptr_reg;

  always_ff @(posedge sys_clk) begin
    if (wr_fire) begin
      mem[wptr_reg[ADDR_W-1:0]] <= filt.write_data; // RULE1 RULE2
    end
  end

  // Gray pointers cross to the other side over two of its own edges
  logic [CNT_W-1:0] wptr_gray;
  logic [CNT_W-1:0] rptr_gray;
  logic [CNT_W-1:0] rg_s1_reg;
  logic [CNT_W-1:0] rg_s2_reg;
  logic [CNT_W-1:0] wg_s1_reg;
  logic [CNT_W-1:0] wg_s2_reg;

  assign wptr_gray = wptr_reg ^ (wptr_reg >> 1); // RULE24
  assign rptr_gray = rptr_reg ^ (rptr_reg >> 1); // RULE24

  // Write side: pointer and the flags timed by write edges
  logic [CNT_W-1:0] wptr_next;
  logic [CNT_W-1:0] wcount;
  logic [CNT_W-1:0] wlevel;
  logic [CNT_W-1:0] af_level;
  logic             full_flag_n_reg;
  logic             almost_full_flag_n_reg;

  assign wptr_next = wptr_reg + {{ADDR_W{1'b0}}, wr_fire};
  assign wcount    = wptr_next - gray2bin(rg_s2_reg);
  assign wlevel    = wptr_reg - gray2bin(rg_s2_reg);
  assign af_level  = DEPTH_C - {1'b0, ofs_full};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wptr_reg               <= '0;
      rg_s1_reg              <= '0;
      rg_s2_reg              <= '0;
      full_flag_n_reg        <= 1'b1; // RULE19
      almost_full_flag_n_reg <= 1'b1; // RULE19
    end else if (ce) begin
      if (pin_rst) begin
        wptr_reg               <= '0; // RULE17 RULE18
        rg_s1_reg              <= '0;
        rg_s2_reg              <= '0;
        full_flag_n_reg        <= 1'b1;
        almost_full_flag_n_reg <= 1'b1;
      end else if (w_ev) begin
        wptr_reg               <= wptr_next; // RULE6
        rg_s1_reg              <= rptr_gray; // RULE24
        rg_s2_reg              <= rg_s1_reg;
        full_flag_n_reg        <= (wcount != DEPTH_C); // RULE12
        almost_full_flag_n_reg <= (wcount < af_level); // RULE14 RULE22
      end
    end
  end

  // Read side: pointer, output word and the flags timed by read edges
  logic [CNT_W-1:0] rptr_next;
  logic [CNT_W-1:0] rcount;
  logic             empty_flag_n_reg;
  logic             almost_empty_flag_n_reg;
  logic [8:0]       read_data_reg;

  assign rptr_next = rptr_reg + {{ADDR_W{1'b0}}, arr_rd};
  assign rcount    = gray2bin(wg_s2_reg) - rptr_next;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rptr_reg                <= '0;
      wg_s1_reg               <= '0;
      wg_s2_reg               <= '0;
      empty_flag_n_reg        <= 1'b0; // RULE19
      almost_empty_flag_n_reg <= 1'b0; // RULE19
      read_data_reg           <= 9'h000;
    end else if (ce) begin
      if (pin_rst) begin
        rptr_reg                <= '0;
        wg_s1_reg               <= '0;
        wg_s2_reg               <= '0;
        empty_flag_n_reg        <= 1'b0; // RULE17
        almost_empty_flag_n_reg <= 1'b0;
        read_data_reg           <= 9'h000; // RULE17
      end else if (r_ev) begin
        rptr_reg                <= rptr_next; // RULE9
        wg_s1_reg               <= wptr_gray; // RULE24
        wg_s2_reg               <= wg_s1_reg;
        empty_flag_n_reg        <= (rcount != '0); // RULE11
        almost_empty_flag_n_reg <= (rcount > {1'b0, ofs_empty}); // RULE13 RULE21
        if (ofs_rd) begin
          read_data_reg <= ofs_cur; // RULE10
        end else if (arr_rd) begin
          read_data_reg <= mem[rptr_reg[ADDR_W-1:0]]; // RULE9
        end
      end
    end
  end

  // Output drive, also gated by the software drive enable
  logic ctrl_drv_reg;
  logic read_data_oe_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      read_data_oe_reg <= 1'b0;
    end else if (ce) begin
      read_data_oe_reg <= !filt.output_enable_n && ctrl_drv_reg; // RULE15
    end
  end

  assign read_data           = read_data_reg;
  assign read_data_oe        = read_data_oe_reg;
  assign empty_flag_n        = empty_flag_n_reg;
  assign full_flag_n         = full_flag_n_reg;
  assign almost_empty_flag_n = almost_empty_flag_n_reg;
  assign almost_full_flag_n  = almost_full_flag_n_reg;

  // AXI4-Lite slave: one write and one read in flight
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic [AXI_AW-1:0] aw_addr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;
  logic [31:0]       stat_word;

  always_comb begin
    stat_word                      = 32'h0000_0000;
    stat_word[`DCF_STAT_EMPTY_BIT] = empty_flag_n_reg;
    stat_word[`DCF_STAT_AEMPT_BIT] = almost_empty_flag_n_reg;
    stat_word[`DCF_STAT_AFULL_BIT] = almost_full_flag_n_reg;
    stat_word[`DCF_STAT_FULL_BIT]  = full_flag_n_reg;
    stat_word[`DCF_STAT_TWOWE_BIT] = !prog_mode;
    stat_word[`DCF_STAT_PRST_BIT]  = pin_rst;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awready_reg  <= 1'b1;
      wready_reg   <= 1'b1;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= `DCF_RESP_OKAY;
      aw_addr_reg  <= '0;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      ctrl_drv_reg <= `DCF_CTRL_RST;
    end else if (ce) begin
      if (s_axi_awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (!awready_reg && !wready_reg && !bvalid_reg) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= addr_known(aw_addr_reg) ? `DCF_RESP_OKAY
                                              : `DCF_RESP_SLVERR;
        if (aw_addr_reg == AXI_AW'(`DCF_CTRL_OFS) && wstrb_reg[0]) begin
          ctrl_drv_reg <= wdata_reg[`DCF_CTRL_DRV_BIT];
        end
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `DCF_RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else if (ce) begin
      if (s_axi_arvalid && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rresp_reg   <= addr_known(s_axi_araddr) ? `DCF_RESP_OKAY
                                                : `DCF_RESP_SLVERR;
        unique case (s_axi_araddr)
          AXI_AW'(`DCF_CTRL_OFS):  rdata_reg <= {31'h0000_0000, ctrl_drv_reg};
          AXI_AW'(`DCF_STAT_OFS):  rdata_reg <= stat_word;
          AXI_AW'(`DCF_LEVEL_OFS): rdata_reg <= 32'(wlevel);
          default:                 rdata_reg <= 32'h0000_0000;
        endcase
      end
      if (rvalid_reg && s_axi_rready) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_mode_hold: assert property ((ce && !pin_rst) |=> $stable(mode_reg)) // RULE3
    else $error("mode changed outside reset");
  a_write_step: assert property (wr_fire |=> // RULE4
    wptr_reg == $past(wptr_reg) + 1'b1)
    else $error("write did not advance pointer");
  a_second_we_gate: assert property ((w_ev && !prog_mode && // RULE5
    !filt.write_enable_second_or_load) |=> $stable(wptr_reg))
    else $error("write taken with second enable low");
  a_full_blocks_write: assert property ((w_ev && !full_flag_n_reg) // RULE6
    |=> $stable(wptr_reg))
    else $error("write taken while full");
  a_ofs_load: assert property (ofs_wr |=> $stable(wptr_reg) && // RULE7
    ofs_reg[$past(ofs_sel_reg)] == $past(filt.write_data))
    else $error("offset load wrong");
  a_read_both: assert property ((r_ev && (filt.read_enable_a_n || // RULE8
    filt.read_enable_b_n)) |=> $stable(rptr_reg) && $stable(read_data_reg))
    else $error("read without both enables");
  a_ofs_readback: assert property (ofs_rd |=> // RULE10
    read_data_reg == $past(ofs_cur) && $stable(rptr_reg))
    else $error("offset readback wrong");
  a_empty_no_read: assert property ((r_ev && !empty_flag_n_reg) // RULE11
    |=> $stable(rptr_reg))
    else $error("read taken while empty");
  a_wflags_hold: assert property ((ce && !w_ev && !pin_rst) // RULE12
    |=> $stable(full_flag_n_reg) && $stable(almost_full_flag_n_reg))
    else $error("write flags moved without write edge");
  a_rflags_hold: assert property ((ce && !r_ev && !pin_rst) // RULE13
    |=> $stable(empty_flag_n_reg) && $stable(almost_empty_flag_n_reg))
    else $error("read flags moved without read edge");
  a_oe_release: assert property ((ce && filt.output_enable_n) // RULE15
    |=> !read_data_oe_reg)
    else $error("outputs driven with output enable high");
  a_reset_empty: assert property ((ce && pin_rst) |=> // RULE17
    !empty_flag_n_reg && read_data_reg == 9'h000 && wptr_reg == '0)
    else $error("pin reset did not empty buffer");
  a_ofs_wrap: assert property ((ofs_wr && ofs_sel_reg == 2'h3) // RULE20
    |=> ofs_sel_reg == 2'h0)
    else $error("offset selector did not wrap");

  c_full: cover property (w_ev ##1 !full_flag_n_reg);
  c_ofs_load: cover property (ofs_wr ##[1:200] ofs_rd);
  c_ae_high: cover property (r_ev ##1 almost_empty_flag_n_reg);
  c_axi_wr: cover property (bvalid_reg && s_axi_bready);

endmodule

// ### hw/dcf_pkg.sv
// Purpose: Types shared by the FIFO design
// Assumes: Nothing beyond SystemVerilog packed types
// Notes:   Pin reset value keeps enables idle and the pin reset active
package dcf_pkg;

  typedef struct packed {
    logic       wr_clk;
    logic       rd_clk;
    logic       write_enable_primary_n;
    logic       write_enable_second_or_load;
    logic       read_enable_a_n;
    logic       read_enable_b_n;
    logic       reset_n;
    logic       output_enable_n;
    logic [8:0] write_data;
  } dcf_pins_t;

  typedef enum logic [1:0] {
    DCF_MODE_PROG   = 2'b01,
    DCF_MODE_TWO_WE = 2'b10
  } dcf_mode_t;

  localparam dcf_pins_t DCF_PINS_RST = '{
    wr_clk: 1'b0, rd_clk: 1'b0,
    write_enable_primary_n: 1'b1, write_enable_second_or_load: 1'b1,
    read_enable_a_n: 1'b1, read_enable_b_n: 1'b1,
    reset_n: 1'b0, output_enable_n: 1'b1, write_data: 9'h000};

endpackage

// ### hw/dcf_regs.svh
// Purpose: Register offsets, field positions and reset values of the FIFO
// Assumes: AXI4-Lite byte addresses, 32-bit data
// Notes:   Included by its bare name
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH

`define DCF_CTRL_OFS       4'h0
`define DCF_STAT_OFS       4'h4
`define DCF_LEVEL_OFS      4'h8

`define DCF_CTRL_DRV_BIT   0
`define DCF_CTRL_RST       1'h1

`define DCF_STAT_EMPTY_BIT 0
`define DCF_STAT_AEMPT_BIT 1
`define DCF_STAT_AFULL_BIT 2
`define DCF_STAT_FULL_BIT  3
`define DCF_STAT_TWOWE_BIT 4
`define DCF_STAT_PRST_BIT  5

`define DCF_OFS_RST        9'h007
`define DCF_OFS_NUM        4

`define DCF_RESP_OKAY      2'h0
`define DCF_RESP_SLVERR    2'h2

`endif
